/* verilog/datapath_regs_pkg.sv */
package datapath_regs_pkg;

  // ==========================================================
  // register offsets on the control bus
  localparam logic [7:0] OFS_DATAPATH = 8'h28;
  localparam logic [7:0] OFS_DITHER = 8'h29;
  localparam logic [7:0] OFS_COLOR = 8'h2a;
  localparam logic [7:0] OFS_AUDIO = 8'h2b;
  localparam logic [7:0] OFS_PCLK = 8'h2e;
  localparam logic [7:0] OFS_DUAL_RX = 8'h34;

  // ==========================================================
  // values after reset
  localparam logic [7:0] RST_DATAPATH = 8'h20;
  localparam logic [7:0] RST_DITHER = 8'h00;
  localparam logic [7:0] RST_COLOR = 8'h00;
  localparam logic [7:0] RST_AUDIO = 8'h00;
  localparam logic [7:0] RST_PCLK = 8'h00;
  localparam logic [7:0] RST_DUAL_RX = 8'h01;

  // ==========================================================
  // writable bit masks, reserved bits stay zero
  localparam logic [7:0] WMASK_DATAPATH = 8'hbf;
  localparam logic [7:0] WMASK_DITHER = 8'hff;
  localparam logic [7:0] WMASK_COLOR = 8'hf0;
  localparam logic [7:0] WMASK_AUDIO = 8'h03;
  localparam logic [7:0] WMASK_PCLK = 8'h80;
  localparam logic [7:0] WMASK_DUAL_RX = 8'h7b;
  // bits the forward channel may load (bit 7 stays local)
  localparam logic [7:0] FCMASK_DATAPATH = 8'h3f;

  // ==========================================================
  // field positions
  localparam int KEEP_LOCAL_BIT = 7;
  localparam int VIDEO_OFF_BIT = 5;
  localparam int DUAL_LINK_BIT = 4;
  localparam int ALT_AUDIO_BIT = 3;
  localparam int AUDIO_OFF_BIT = 2;
  localparam int VIDEO28_BIT = 1;
  localparam int SURROUND_BIT = 0;
  localparam int TIMING_MODE_BIT = 7;
  localparam int LINE_SENSE_BIT = 6;
  localparam int FRAME_SENSE_BIT = 5;
  localparam int ACTIVE_SENSE_BIT = 4;
  localparam int DITHER_TWO_BIT = 3;
  localparam int DITHER_ONE_BIT = 2;
  localparam int FINE_TWO_OFF_BIT = 1;
  localparam int FINE_ONE_OFF_BIT = 0;
  localparam int PAGE_MSB = 7;
  localparam int PAGE_LSB = 6;
  localparam int WB_ON_BIT = 5;
  localparam int TABLE_REFRESH_BIT = 4;
  localparam int OVERRUN_BIT = 3;
  localparam int UNDERRUN_BIT = 2;
  localparam int FIFO_CLEAR_BIT = 1;
  localparam int RISE_EDGE_BIT = 0;
  localparam int TEST_CLOCK_BIT = 7;
  localparam int LANE_MODE_MSB = 4;
  localparam int LANE_MODE_LSB = 3;

  // ==========================================================
  // receive lane modes
  typedef enum logic [1:0] {
    LANE_AUTO = 2'b00,
    LANE_DUAL = 2'b01,
    LANE_PRIMARY = 2'b10,
    LANE_SECONDARY = 2'b11
  } lane_mode_t;

  // control bus request, one cycle per strobe
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  // video timing group
  typedef struct packed {
    logic line_sync;
    logic frame_sync;
    logic active_pixel_flag;
  } video_sync_t;

endpackage : datapath_regs_pkg

/* verilog/sticky_flag.sv */
`timescale 1ns/1ps
// ==========================================================
// sticky event flag, a set in the clear cycle is kept
module sticky_flag (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic set,
  input wire logic clr,
  output logic q
);
  logic next_q; // set wins so no event is lost
  assign next_q = set | (q & ~clr);

  // flag register
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= 1'b0;
    end else begin
      q <= next_q;
    end
  end
endmodule : sticky_flag

/* verilog/sync_normalizer.sv */
`timescale 1ns/1ps
// ==========================================================
// turns sync inputs to active high, derives pixel valid
module sync_normalizer (
  input wire logic sys_clk,
  input wire logic arst_n,
  input datapath_regs_pkg::video_sync_t raw,
  input wire logic [2:0] sense,
  input wire logic sync_mode,
  output datapath_regs_pkg::video_sync_t norm,
  output logic pixel_valid
);
  import datapath_regs_pkg::*;

  video_sync_t next_norm; // polarity removed
  logic next_valid; // mode dependent window
  // sense bit 1 means active low, so xor undoes it
  assign next_norm = raw ^ video_sync_t'(sense);
  // sync mode blanks on either sync, otherwise the flag alone
  assign next_valid = sync_mode ? ~(next_norm.line_sync | next_norm.frame_sync)
                                : next_norm.active_pixel_flag;

  // one stage of flops keeps outputs glitch free
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      norm <= '0;
      pixel_valid <= 1'b0;
    end else begin
      norm <= next_norm;
      pixel_valid <= next_valid;
    end
  end
endmodule : sync_normalizer

/* verilog/video_audio_datapath_regs.sv */
`timescale 1ns/1ps
// Contract
// - keep-local bit blocks forward channel loads
// - video-off bit resets to one, link stays
// - link-width bit steers auto lane detection
// - alternate audio on general pins one, zero
// - audio-off bit stops the serial audio except on the general pins
// - 28-bit video carries sync and active flag
// - surround bit enables surround audio
// - timing mode selects flag or syncs
// - sense bits set sync polarities
// - two bits enable dither stages
// - two bits disable fine dither
// - page field selects config or colour table
// - white balance on or bypassed
// - colour table refresh enable
// - read-only overrun and underrun flags
// - writing one clears both fifo flags
// - edge bit picks audio strobe edge
// - test bit takes pixel clock from pin
// - four receive lane modes
module video_audio_datapath_regs (
  input wire logic sys_clk,
  input wire logic arst_n,
  // control bus register port
  input datapath_regs_pkg::reg_req_t req,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // forward channel update of the datapath register
  input wire logic fc_load,
  input wire logic [7:0] fc_data,
  // audio fifo events from the audio path
  input wire logic fifo_overrun_evt,
  input wire logic fifo_underrun_evt,
  output logic fifo_clear,
  // audio sources and normal pin drive
  input wire logic audio_word_clk,
  input wire logic audio_sdata,
  input wire logic [1:0] pin_out_normal,
  input wire logic [1:0] pin_oe_normal,
  output logic general_pin_zero_o,
  output logic general_pin_zero_oe,
  output logic general_pin_one_o,
  output logic general_pin_one_oe,
  // video timing in and normalised out
  input datapath_regs_pkg::video_sync_t sync_in,
  output datapath_regs_pkg::video_sync_t sync_out,
  output logic pixel_valid,
  // datapath controls
  output logic video_active,
  output logic ctrl_channel_on,
  output logic audio_out_on,
  output logic surround_on,
  output logic video_28bit,
  output logic audio_rise_edge,
  output logic pclk_from_test_pin,
  // receive lane steering
  output logic rx_dual_lane,
  output logic rx_use_secondary,
  // dithering
  output logic dither_stage_one_on,
  output logic dither_stage_two_on,
  output logic fine_dither_one_on,
  output logic fine_dither_two_on,
  // white balance
  output logic white_balance_on,
  output logic table_refresh_on,
  output logic [3:0] table_select
);
  import datapath_regs_pkg::*;

  // ==========================================================
  // helpers

  // masked write keeps reserved bits at zero
  function automatic logic [7:0] merge(input logic [7:0] old,
                                       input logic [7:0] val,
                                       input logic [7:0] mask);
    merge = (old & ~mask) | (val & mask);
  endfunction : merge

  // page code to one-hot: config, red, green, blue
  function automatic logic [3:0] page_hot(input logic [1:0] code);
    page_hot = 4'h1 << code;
  endfunction : page_hot

  // ==========================================================
  // storage
  logic [7:0] datapath_setup_two; // link and audio options
  logic [7:0] dither_sync_setup; // timing and dither
  logic [7:0] color_gain_setup; // white balance page
  logic [7:0] audio_port_setup; // writable part only
  logic [7:0] pixel_clock_test; // clock source
  logic [7:0] dual_receiver_setup; // lane mode
  logic fifo_overrun; // sticky status
  logic fifo_underrun; // sticky status

  // ==========================================================
  // address decode
  logic hit_datapath;
  logic hit_dither;
  logic hit_color;
  logic hit_audio;
  logic hit_pclk;
  logic hit_dual_rx;
  assign hit_datapath = (req.addr == OFS_DATAPATH);
  assign hit_dither = (req.addr == OFS_DITHER);
  assign hit_color = (req.addr == OFS_COLOR);
  assign hit_audio = (req.addr == OFS_AUDIO);
  assign hit_pclk = (req.addr == OFS_PCLK);
  assign hit_dual_rx = (req.addr == OFS_DUAL_RX);

  logic wr_datapath;
  logic wr_dither;
  logic wr_color;
  logic wr_audio;
  logic wr_pclk;
  logic wr_dual_rx;
  assign wr_datapath = req.wr & hit_datapath;
  assign wr_dither = req.wr & hit_dither;
  assign wr_color = req.wr & hit_color;
  assign wr_audio = req.wr & hit_audio;
  assign wr_pclk = req.wr & hit_pclk;
  assign wr_dual_rx = req.wr & hit_dual_rx;

  // ==========================================================
  // datapath register next value

  // forward channel only loads while local keep is clear
  logic fc_allowed;
  assign fc_allowed = fc_load & ~datapath_setup_two[KEEP_LOCAL_BIT];

  // a local write in the same cycle wins over the link,
  // since software has the last word on its own setting
  logic [7:0] next_datapath;
  assign next_datapath = wr_datapath ?
      merge(datapath_setup_two, req.wdata, WMASK_DATAPATH) :
      fc_allowed ? merge(datapath_setup_two, fc_data, FCMASK_DATAPATH) :
      datapath_setup_two;

  // ==========================================================
  // plain registers next values
  logic [7:0] next_dither;
  logic [7:0] next_color;
  logic [7:0] next_audio;
  logic [7:0] next_pclk;
  logic [7:0] next_dual_rx;
  assign next_dither = wr_dither ?
      merge(dither_sync_setup, req.wdata, WMASK_DITHER) : dither_sync_setup;
  assign next_color = wr_color ?
      merge(color_gain_setup, req.wdata, WMASK_COLOR) : color_gain_setup;
  assign next_audio = wr_audio ?
      merge(audio_port_setup, req.wdata, WMASK_AUDIO) : audio_port_setup;
  assign next_pclk = wr_pclk ?
      merge(pixel_clock_test, req.wdata, WMASK_PCLK) : pixel_clock_test;
  assign next_dual_rx = wr_dual_rx ?
      merge(dual_receiver_setup, req.wdata, WMASK_DUAL_RX) : dual_receiver_setup;

  // ==========================================================
  // register bank
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      datapath_setup_two <= RST_DATAPATH;
      dither_sync_setup <= RST_DITHER;
      color_gain_setup <= RST_COLOR;
      audio_port_setup <= RST_AUDIO;
      pixel_clock_test <= RST_PCLK;
      dual_receiver_setup <= RST_DUAL_RX;
    end else begin
      datapath_setup_two <= next_datapath;
      dither_sync_setup <= next_dither;
      color_gain_setup <= next_color;
      audio_port_setup <= next_audio;
      pixel_clock_test <= next_pclk;
      dual_receiver_setup <= next_dual_rx;
    end
  end

  // ==========================================================
  // audio fifo status

  // the clear fires once per write of one, even if the
  // stored bit already was one
  assign fifo_clear = wr_audio & req.wdata[FIFO_CLEAR_BIT];

  sticky_flag u_overrun (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .set(fifo_overrun_evt),
    .clr(fifo_clear),
    .q(fifo_overrun)
  );

  sticky_flag u_underrun (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .set(fifo_underrun_evt),
    .clr(fifo_clear),
    .q(fifo_underrun)
  );

  // ==========================================================
  // read path
  logic [7:0] audio_view; // status merged over stored bits
  assign audio_view = {4'h0, fifo_overrun, fifo_underrun,
                       audio_port_setup[1:0]};

  // unmapped offsets read zero
  logic [7:0] next_rdata;
  assign next_rdata = hit_datapath ? datapath_setup_two :
                      hit_dither ? dither_sync_setup :
                      hit_color ? color_gain_setup :
                      hit_audio ? audio_view :
                      hit_pclk ? pixel_clock_test :
                      hit_dual_rx ? dual_receiver_setup : 8'h00;

  // read data held until the next read
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= req.rd;
      if (req.rd) begin
        reg_rdata <= next_rdata;
      end
    end
  end

  // ==========================================================
  // receive lane steering
  lane_mode_t lane_mode; // receive_lane_mode field
  assign lane_mode = lane_mode_t'(dual_receiver_setup[LANE_MODE_MSB:LANE_MODE_LSB]);

  logic next_dual;
  logic next_secondary;
  always_comb begin
    next_dual = 1'b0;
    next_secondary = 1'b0;
    case (lane_mode)
      // follow the far serializer's link width
      LANE_AUTO: begin
        next_dual = datapath_setup_two[DUAL_LINK_BIT];
      end
      LANE_DUAL: begin
        next_dual = 1'b1;
      end
      LANE_PRIMARY: begin
        next_dual = 1'b0;
      end
      LANE_SECONDARY: begin
        next_secondary = 1'b1;
      end
      default: begin
        next_dual = 1'b0;
      end
    endcase
  end

  // ==========================================================
  // general pin muxing
  logic alt_audio;
  assign alt_audio = datapath_setup_two[ALT_AUDIO_BIT];
  logic [1:0] next_pin_o;
  logic [1:0] next_pin_oe;
  // pin one carries word clock, pin zero serial data
  assign next_pin_o = alt_audio ? {audio_word_clk, audio_sdata}
                                : pin_out_normal;
  assign next_pin_oe = alt_audio ? 2'b11 : pin_oe_normal;

  // ==========================================================
  // control outputs, all from flops
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_dual_lane <= 1'b0;
      rx_use_secondary <= 1'b0;
      general_pin_zero_o <= 1'b0;
      general_pin_one_o <= 1'b0;
      general_pin_zero_oe <= 1'b0;
      general_pin_one_oe <= 1'b0;
    end else begin
      rx_dual_lane <= next_dual;
      rx_use_secondary <= next_secondary;
      general_pin_zero_o <= next_pin_o[0];
      general_pin_one_o <= next_pin_o[1];
      general_pin_zero_oe <= next_pin_oe[0];
      general_pin_one_oe <= next_pin_oe[1];
    end
  end

  // ==========================================================
  // field decodes straight from the stored bits
  // no video does not stop control channel or pins
  assign video_active = ~datapath_setup_two[VIDEO_OFF_BIT];
  assign ctrl_channel_on = 1'b1;
  assign audio_out_on = ~datapath_setup_two[AUDIO_OFF_BIT];
  assign surround_on = datapath_setup_two[SURROUND_BIT];
  assign video_28bit = datapath_setup_two[VIDEO28_BIT];
  assign audio_rise_edge = audio_port_setup[RISE_EDGE_BIT];
  assign pclk_from_test_pin = pixel_clock_test[TEST_CLOCK_BIT];

  assign dither_stage_one_on = dither_sync_setup[DITHER_ONE_BIT];
  assign dither_stage_two_on = dither_sync_setup[DITHER_TWO_BIT];
  assign fine_dither_one_on = ~dither_sync_setup[FINE_ONE_OFF_BIT];
  assign fine_dither_two_on = ~dither_sync_setup[FINE_TWO_OFF_BIT];

  assign white_balance_on = color_gain_setup[WB_ON_BIT];
  assign table_refresh_on = color_gain_setup[TABLE_REFRESH_BIT];
  assign table_select = page_hot(color_gain_setup[PAGE_MSB:PAGE_LSB]);

  // ==========================================================
  // video timing
  logic [2:0] sense; // line, frame, active polarity
  assign sense = {dither_sync_setup[LINE_SENSE_BIT],
                  dither_sync_setup[FRAME_SENSE_BIT],
                  dither_sync_setup[ACTIVE_SENSE_BIT]};

  // when not carried as 28-bit video the sync bits are
  // not meaningful, so they read as idle
  video_sync_t sync_gated;
  assign sync_gated = video_28bit ? sync_in : (sync_in & 3'b001 | 3'b000);

  sync_normalizer u_sync (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .raw(video_sync_t'(sync_gated ^ (video_28bit ? 3'b000 : {sense[2:1], 1'b0}))),
    .sense(sense),
    .sync_mode(dither_sync_setup[TIMING_MODE_BIT]),
    .norm(sync_out),
    .pixel_valid(pixel_valid)
  );

endmodule : video_audio_datapath_regs

/* dv/video_audio_datapath_regs_checker.sv */
`timescale 1ns/1ps
// ==========================================================
// port checker for the datapath register bank
module video_audio_datapath_regs_checker (
  input wire logic sys_clk,
  input wire logic arst_n,
  input datapath_regs_pkg::reg_req_t req,
  input wire logic fc_load,
  input wire logic [7:0] fc_data,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic fifo_clear,
  input wire logic audio_word_clk,
  input wire logic audio_sdata,
  input wire logic general_pin_zero_o,
  input wire logic general_pin_zero_oe,
  input wire logic general_pin_one_o,
  input wire logic general_pin_one_oe,
  input wire logic video_active,
  input wire logic ctrl_channel_on,
  input wire logic audio_out_on,
  input wire logic surround_on,
  input wire logic video_28bit,
  input wire logic rx_dual_lane,
  input wire logic rx_use_secondary,
  input wire logic [3:0] table_select
);
  import datapath_regs_pkg::*;
  // ==========================================================
  // shadows rebuilt from bus and link traffic
  logic [7:0] dp_q; // datapath register image
  logic [1:0] pg_q; // colour page field
  logic [1:0] mode_q; // receive lane mode
  wire wr_dp = req.wr && req.addr == OFS_DATAPATH; // a local write beats a link load
  wire fc_ok = fc_load && !wr_dp && !dp_q[KEEP_LOCAL_BIT];
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      dp_q <= RST_DATAPATH;
      pg_q <= 2'h0;
      mode_q <= RST_DUAL_RX[4:3];
    end else begin
      if (wr_dp) begin
        dp_q <= req.wdata & WMASK_DATAPATH;
      end else if (fc_ok) begin
        dp_q <= (dp_q & ~FCMASK_DATAPATH) | (fc_data & FCMASK_DATAPATH);
      end
      if (req.wr && req.addr == OFS_COLOR) begin
        pg_q <= req.wdata[7:6];
      end
      if (req.wr && req.addr == OFS_DUAL_RX) begin
        mode_q <= req.wdata[4:3];
      end
    end
  end
  // ==========================================================
  // properties
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  // mode held two samples, since the lane outputs lag by a cycle
  sequence s_mode_held(logic [1:0] m);
    mode_q == m ##1 mode_q == m;
  endsequence
  property p_lane(logic [1:0] m, logic dual, logic sec);
    s_mode_held(m) |-> rx_dual_lane == dual && rx_use_secondary == sec;
  endproperty
  a_read_datapath: assert property (req.rd && req.addr == OFS_DATAPATH
    |=> reg_rvalid && reg_rdata == $past(dp_q)) else $error("datapath readback wrong");
  a_keep_local: assert property (fc_load && !wr_dp && dp_q[KEEP_LOCAL_BIT]
    |=> $stable(video_28bit) && $stable(surround_on) && $stable(audio_out_on))
    else $error("link load not blocked");
  a_video_status: assert property (video_active == !dp_q[VIDEO_OFF_BIT] && ctrl_channel_on)
    else $error("video status wrong");
  a_audio_enables: assert property (audio_out_on == !dp_q[AUDIO_OFF_BIT]
    && surround_on == dp_q[SURROUND_BIT] && video_28bit == dp_q[VIDEO28_BIT])
    else $error("datapath enables wrong");
  a_alt_pin_route: assert property (dp_q[ALT_AUDIO_BIT] |=> general_pin_one_o ==
    $past(audio_word_clk) && general_pin_zero_o == $past(audio_sdata)
    && general_pin_one_oe && general_pin_zero_oe) else $error("alternate audio pins wrong");
  a_fifo_clear_cause: assert property (fifo_clear == (req.wr && req.addr == OFS_AUDIO
    && req.wdata[FIFO_CLEAR_BIT])) else $error("fifo clear pulse wrong");
  a_page_onehot: assert property (table_select == 4'h1 << pg_q)
    else $error("table select wrong");
  a_lane_dual: assert property (p_lane(2'b01, 1'b1, 1'b0))
    else $error("dual lane mode wrong");
  a_lane_secondary: assert property (p_lane(2'b11, 1'b0, 1'b1))
    else $error("secondary lane mode wrong");
endmodule : video_audio_datapath_regs_checker

bind video_audio_datapath_regs video_audio_datapath_regs_checker u_checker (
  .sys_clk, .arst_n, .req, .fc_load, .fc_data, .reg_rdata, .reg_rvalid, .fifo_clear,
  .audio_word_clk, .audio_sdata, .general_pin_zero_o, .general_pin_zero_oe,
  .general_pin_one_o, .general_pin_one_oe, .video_active, .ctrl_channel_on, .audio_out_on,
  .surround_on, .video_28bit, .rx_dual_lane, .rx_use_secondary, .table_select
);

/* dv/fc_serializer_model.sv */
`timescale 1ns/1ps
// ==========================================================
// remote serializer: link loads, audio lines, fifo events
module fc_serializer_model (
  input wire logic sys_clk,
  output logic fc_load,
  output logic [7:0] fc_data,
  output logic audio_word_clk,
  output logic audio_sdata,
  output logic fifo_overrun_evt,
  output logic fifo_underrun_evt
);
  logic [3:0] pat = 4'h0; // steps by 5 every cycle, but the two audio lines can show the same pair in two cycles running
  assign audio_word_clk = pat[1];
  assign audio_sdata = pat[0] ^ pat[3];
  initial begin
    fc_load = 1'b0;
    fc_data = 8'h00;
    fifo_overrun_evt = 1'b0;
    fifo_underrun_evt = 1'b0;
  end
  always @(posedge sys_clk) begin
    pat <= pat + 4'h5;
  end
  // one link load; afterwards the data lines show the inverse, not the old value
  task automatic send_fc(input logic [7:0] v);
    @(negedge sys_clk);
    fc_data = v;
    fc_load = 1'b1;
    @(negedge sys_clk);
    fc_load = 1'b0;
    fc_data = ~v;
  endtask : send_fc
  // one-cycle fifo event pulses
  task automatic pulse_evt(input logic ovr, input logic und);
    @(negedge sys_clk);
    fifo_overrun_evt = ovr;
    fifo_underrun_evt = und;
    @(negedge sys_clk);
    fifo_overrun_evt = 1'b0;
    fifo_underrun_evt = 1'b0;
  endtask : pulse_evt
endmodule : fc_serializer_model

/* dv/video_audio_datapath_regs_tb.sv */
`timescale 1ns/1ps
// ==========================================================
// self-checking bench for the datapath register bank
module video_audio_datapath_regs_tb;
  import datapath_regs_pkg::*;
  logic sys_clk, arst_n, fc_load, fifo_overrun_evt, fifo_underrun_evt, fifo_clear;
  logic audio_word_clk, audio_sdata, reg_rvalid, pixel_valid, video_active, ctrl_channel_on;
  logic general_pin_zero_o, general_pin_zero_oe, general_pin_one_o, general_pin_one_oe;
  logic audio_out_on, surround_on, video_28bit, audio_rise_edge, pclk_from_test_pin;
  logic rx_dual_lane, rx_use_secondary, dither_stage_one_on, dither_stage_two_on;
  logic fine_dither_one_on, fine_dither_two_on, white_balance_on, table_refresh_on;
  logic [7:0] fc_data, reg_rdata, d;
  logic [1:0] pin_out_normal, pin_oe_normal;
  logic [3:0] table_select, e;
  reg_req_t req;
  video_sync_t sync_in, sync_out;
  logic [7:0] sh [6]; // expected register contents
  logic [7:0] ofs [6] = '{OFS_DATAPATH, OFS_DITHER, OFS_COLOR, OFS_AUDIO, OFS_PCLK, OFS_DUAL_RX};
  logic [7:0] msk [6] = '{WMASK_DATAPATH, WMASK_DITHER, WMASK_COLOR, WMASK_AUDIO, WMASK_PCLK,
    WMASK_DUAL_RX};
  int error_cnt = 0;
  int comparisons = 0;
  int seed = 32'h5f40;
  int k;
  // all register-driven outputs in one word
  wire [17:0] act_view = {video_active, audio_out_on, surround_on, video_28bit, audio_rise_edge,
    pclk_from_test_pin, dither_stage_one_on, dither_stage_two_on, fine_dither_one_on,
    fine_dither_two_on, white_balance_on, table_refresh_on, table_select, rx_dual_lane,
    rx_use_secondary};
  video_audio_datapath_regs u_video_audio_datapath_regs (
    .sys_clk, .arst_n, .req, .reg_rdata, .reg_rvalid, .fc_load, .fc_data, .fifo_overrun_evt,
    .fifo_underrun_evt, .fifo_clear, .audio_word_clk, .audio_sdata, .pin_out_normal,
    .pin_oe_normal, .general_pin_zero_o, .general_pin_zero_oe, .general_pin_one_o,
    .general_pin_one_oe, .sync_in, .sync_out, .pixel_valid, .video_active, .ctrl_channel_on,
    .audio_out_on, .surround_on, .video_28bit, .audio_rise_edge, .pclk_from_test_pin,
    .rx_dual_lane, .rx_use_secondary, .dither_stage_one_on, .dither_stage_two_on,
    .fine_dither_one_on, .fine_dither_two_on, .white_balance_on, .table_refresh_on,
    .table_select
  );
  fc_serializer_model u_fc_serializer_model (
    .sys_clk, .fc_load, .fc_data, .audio_word_clk, .audio_sdata, .fifo_overrun_evt,
    .fifo_underrun_evt
  );
  always #5 sys_clk = ~sys_clk;
  // ==========================================================
  // expected outputs from the shadow registers
  function automatic logic [17:0] exp_view();
    logic [7:0] p, f, c;
    logic [1:0] m;
    p = sh[0];
    f = sh[1];
    c = sh[2];
    m = sh[5][4:3];
    return {~p[5], ~p[2], p[0], p[1], sh[3][0], sh[4][7], f[2], f[3], ~f[0], ~f[1], c[5], c[4],
      4'h1 << c[7:6], m == 2'b01 || (m == 2'b00 && p[4]), m == 2'b11};
  endfunction : exp_view
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // bus tasks start just after a falling edge and end one idle cycle later
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    req.wr = 1'b1;
    req.addr = a;
    req.wdata = v;
    @(negedge sys_clk);
    req.wr = 1'b0;
    @(negedge sys_clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    req.rd = 1'b1;
    req.addr = a;
    @(negedge sys_clk);
    req.rd = 1'b0;
    v = reg_rdata;
    chk(reg_rvalid, 1'b1);
    @(negedge sys_clk);
  endtask : rd
  task automatic give_verdict();
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : give_verdict
  // watchdog: the sequence needs about 400 cycles, the limit is 5000
  initial begin
    #50us;
    error_cnt++;
    give_verdict();
  end
  initial begin
    sys_clk = 1'b0;
    arst_n = 1'b0;
    req = '0;
    pin_out_normal = 2'h0;
    pin_oe_normal = 2'h0;
    sync_in = '0;
    sh = '{RST_DATAPATH, RST_DITHER, RST_COLOR, RST_AUDIO, RST_PCLK, RST_DUAL_RX};
    repeat (8) @(negedge sys_clk);
    arst_n = 1'b1;
    // reset values, then one unmapped offset
    for (int i = 0; i < 6; i++) begin
      rd(ofs[i], d);
      chk(d, sh[i]);
    end
    rd(8'h2c, d);
    chk(d, 8'h00);
    chk(act_view, exp_view());
    // all-ones writes first, then random ones
    for (int n = 0; n < 66; n++) begin
      k = n < 6 ? n : {$random(seed)} % 6;
      d = n < 6 ? 8'hff : 8'($random(seed));
      wr(ofs[k], d);
      sh[k] = d & msk[k];
      rd(ofs[k], d);
      chk(d, sh[k]);
      chk(act_view, exp_view());
      chk(act_view, exp_view());
    end
    // every lane mode in turn
    for (int m = 0; m < 4; m++) begin
      sh[5] = {3'h0, 2'(m), 3'h1};
      wr(OFS_DUAL_RX, sh[5]);
      chk(act_view, exp_view());
    end
    // link load accepted, then blocked by the keep-local bit
    wr(OFS_DATAPATH, 8'h00);
    d = 8'($random(seed)) | 8'h40;
    u_fc_serializer_model.send_fc(d);
    sh[0] = d & FCMASK_DATAPATH;
    rd(OFS_DATAPATH, d);
    chk(d, sh[0]);
    wr(OFS_DATAPATH, 8'h80);
    u_fc_serializer_model.send_fc(8'h3f);
    rd(OFS_DATAPATH, d);
    chk(d, 8'h80);
    // fifo flags set by events, read-only, cleared by a one in bit 1
    u_fc_serializer_model.pulse_evt(1'b1, 1'b0);
    rd(OFS_AUDIO, d);
    chk(d & 8'h0c, 8'h08);
    u_fc_serializer_model.pulse_evt(1'b0, 1'b1);
    rd(OFS_AUDIO, d);
    chk(d & 8'h0c, 8'h0c);
    wr(OFS_AUDIO, 8'h0e);
    rd(OFS_AUDIO, d);
    chk(d, 8'h02);
    // pins: normal drive, then alternate audio
    for (int a = 0; a < 2; a++) begin
      wr(OFS_DATAPATH, a ? 8'h08 : 8'h00);
      repeat (12) begin
        pin_out_normal = 2'($random(seed));
        pin_oe_normal = 2'($random(seed));
        e = a ? {audio_word_clk, audio_sdata, 2'b11} : {pin_out_normal, pin_oe_normal};
        @(negedge sys_clk);
        chk({general_pin_one_o, general_pin_zero_o, general_pin_one_oe, general_pin_zero_oe}, e);
      end
    end
    // flag-only timing, then 28-bit sync mode, both line and active senses, frame sense bit at zero
    for (int s = 0; s < 4; s++) begin
      wr(OFS_DATAPATH, {6'h0, s[1], 1'b0});
      wr(OFS_DITHER, {s[1], s[0], 1'b0, s[0], 4'h0});
      repeat (8) begin
        sync_in = 3'($random(seed));
        e[2:0] = s[1] ? sync_in ^ {s[0], 1'b0, s[0]} : {2'h0, sync_in.active_pixel_flag ^ s[0]};
        e[3] = s[1] ? ~(e[2] | e[1]) : e[0];
        @(negedge sys_clk);
        chk(pixel_valid, e[3]);
        chk(sync_out, e[2:0]);
      end
    end
    give_verdict();
  end
endmodule : video_audio_datapath_regs_tb
